// >>> rtl/dsod_pkg.sv
package dsod_pkg;

    // ****************************************
    // apb register map
    // ****************************************
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  STATUS_OFFSET = 8'h00;   // read only
    localparam logic [7:0]  SPIN_CMD_OFFSET = 8'h04; // write only, reads zero

    // status fields
    localparam int          ST_ID_LSB     = 0;       // three bits
    localparam int          ST_WP_BIT     = 3;
    localparam int          ST_DIAG_BIT   = 4;
    localparam int          ST_START_BIT  = 5;
    localparam int          ST_SPIN_BIT   = 6;
    localparam int          ST_LATCH_BIT  = 7;

    // spindle command fields
    localparam int          CMD_START_BIT = 0;
    localparam int          CMD_STOP_BIT  = 1;

    // ****************************************
    // strap vector layout and reset values
    // ****************************************
    localparam int          STRAP_W       = 14;
    localparam int          SV_ID_LSB     = 0;       // three bits
    localparam int          SV_WP_BIT     = 3;
    localparam int          SV_DIAG_BIT   = 4;
    localparam int          SV_START_BIT  = 5;
    localparam int          SV_ARB_LSB    = 6;       // eight bits
    localparam logic [2:0]  BUS_ID_RST    = 3'h0;
    localparam logic [13:0] STRAP_RST     = 14'h0000;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_PERIOD_PS = 5000;
    localparam int          LATCH_WAIT_PS = 20000;   // settle time after reset release
    localparam int          LATCH_WAIT_CYC = (LATCH_WAIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0]  LATCH_WAIT_CNT = 3'(LATCH_WAIT_CYC);

    typedef enum logic [1:0] {SPIN_WAIT, SPIN_STOPPED, SPIN_RUNNING} dsod_spin_e;

endpackage

// >>> rtl/dsod_sync_if.sv
`timescale 1ns/1ps
interface dsod_sync_if;
    logic [dsod_pkg::STRAP_W-1:0] raw;   // asynchronous strap and pin levels
    logic [dsod_pkg::STRAP_W-1:0] q;     // filtered levels in pclk domain
    modport mon (output raw, input q);
    modport syn (input raw, output q);
endinterface

// >>> rtl/dsod_strap_sync.sv
`timescale 1ns/1ps
module dsod_strap_sync (
    input  wire logic  pclk,
    input  wire logic  presetn,
    dsod_sync_if.syn   sif
);
    typedef struct packed {
        logic [dsod_pkg::STRAP_W-1:0] s1;
        logic [dsod_pkg::STRAP_W-1:0] s2;
        logic [dsod_pkg::STRAP_W-1:0] s3;
        logic [dsod_pkg::STRAP_W-1:0] q;
    } dsod_sync_s;

    dsod_sync_s st_reg;
    dsod_sync_s st_next;

    // ****************************************
    // three stages, change taken once s2 and s3 agree
    // ****************************************
    // a bouncing plug is ignored until two samples match
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = sif.raw;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        st_next.q  = (st_reg.s2 & st_reg.s3) | (st_reg.q & (st_reg.s2 ^ st_reg.s3));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{default: dsod_pkg::STRAP_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign sif.q = st_reg.q;

endmodule

// >>> rtl/dsod_strap_decoder.sv
`timescale 1ns/1ps
// Behaviour
// RQ1 - bus identifier is three strap bits, fitted reads one, all fitted gives seven
// RQ2 - in arbitration the highest identifier present wins, seven beats everyone
// RQ3 - integrator gives distinct identifiers and at most eight parties per bus
// RQ4 - write-protect strap removed refuses medium writes; fitted allows them
// RQ5 - write-protect and self-test straps act live; others need a power cycle
// RQ6 - start-mode fitted spins up at power-on; removed waits for start command
// RQ7 - start-mode affects power-on only; start/stop commands always act (here they are ignored until the straps are latched)
// RQ8 - active-low operator panel inputs may set identifier bits instead of straps
// RQ9 - identifier and start-mode are latched once after reset release and held
module dsod_strap_decoder (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [dsod_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // straps, fitted plug reads one
    input  wire logic [2:0]                  identifier_strap_header,
    input  wire logic                        wp_strap,
    input  wire logic                        self_test_strap,
    input  wire logic                        start_mode_strap,
    // operator panel, all active low
    input  wire logic                        panel_id_bit2_n,
    input  wire logic                        panel_id_bit1,
    input  wire logic                        panel_id_bit0_n,
    // arbitration, bus data lines as seen on the bus
    input  wire logic [7:0]                  arb_bus,
    input  wire logic                        arb_phase,
    // medium write request from the controller
    input  wire logic                        wr_req,
    output logic                             wr_grant,
    output logic                             wr_refused,
    output logic [2:0]                       bus_id,
    output logic                             self_test_mode,
    output logic                             spindle_run,
    output logic                             arb_win
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0]           wait_cnt;
        dsod_pkg::dsod_spin_e spin;
        logic                 latched;
        logic [2:0]           bus_id;
        logic                 start_fit;
        logic                 spindle;
        logic                 self_test;
        logic                 wr_grant;
        logic                 wr_refused;
        logic                 arb_win;
        logic                 pready;
        logic                 pslverr;
        logic [31:0]          prdata;
    } dsod_top_s;

    dsod_top_s st_reg;
    dsod_top_s st_next;

    dsod_sync_if sif ();

    logic [2:0] id_live;
    logic       wp_fit;
    logic [7:0] arb_live;
    logic       apb_done;
    logic       cmd_wr;
    logic       cmd_start;
    logic       cmd_stop;
    logic       latch_now;

    // true when our bit is on the bus and no higher one is
    function automatic logic arb_wins(input logic [7:0] bus, input logic [2:0] id);
        logic win;
        win = bus[id];
        for (int i = 0; i < 8; i++) begin
            if (i > int'(id) && bus[i]) begin
                win = 1'b0;
            end
        end
        return win;
    endfunction

    // ****************************************
    // strap capture
    // ****************************************
    // panel pulls a bit as if the plug were fitted; its strap must be open
    assign sif.raw = {arb_bus,
                      start_mode_strap,
                      self_test_strap,
                      wp_strap,
                      identifier_strap_header | {~panel_id_bit2_n, ~panel_id_bit1,
                                                 ~panel_id_bit0_n}}; // RQ8 RQ1

    dsod_strap_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    assign id_live  = sif.q[dsod_pkg::SV_ID_LSB +: 3];
    assign wp_fit   = sif.q[dsod_pkg::SV_WP_BIT];
    assign arb_live = sif.q[dsod_pkg::SV_ARB_LSB +: 8];

    // ****************************************
    // apb decode
    // ****************************************
    // one wait state: pready rises on the second access cycle
    assign apb_done  = psel & penable & st_reg.pready;
    assign cmd_wr    = apb_done & pwrite & (paddr == dsod_pkg::SPIN_CMD_OFFSET);
    assign cmd_start = cmd_wr & pwdata[dsod_pkg::CMD_START_BIT];
    assign cmd_stop  = cmd_wr & pwdata[dsod_pkg::CMD_STOP_BIT];
    assign latch_now = (st_reg.spin == dsod_pkg::SPIN_WAIT) &&
                       (st_reg.wait_cnt == dsod_pkg::LATCH_WAIT_CNT);

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next            = st_reg;
        st_next.pready     = psel & penable & ~st_reg.pready;
        st_next.pslverr    = 1'b0;
        st_next.wr_grant   = wr_req & wp_fit;   // RQ4
        st_next.wr_refused = wr_req & ~wp_fit;  // RQ4 RQ5
        st_next.self_test  = sif.q[dsod_pkg::SV_DIAG_BIT]; // RQ5
        // highest identifier wins, with our latched id only
        st_next.arb_win    = arb_phase & st_reg.latched &
                             arb_wins(arb_live, st_reg.bus_id); // RQ2

        // read data and error on the edge that raises pready
        if (psel && penable && !st_reg.pready) begin
            st_next.prdata = 32'h0000_0000;
            if (paddr == dsod_pkg::STATUS_OFFSET) begin
                st_next.pslverr = pwrite;  // status is read only
                st_next.prdata[dsod_pkg::ST_ID_LSB +: 3] = st_reg.bus_id;
                st_next.prdata[dsod_pkg::ST_WP_BIT]      = wp_fit;
                st_next.prdata[dsod_pkg::ST_DIAG_BIT]    = st_reg.self_test;
                st_next.prdata[dsod_pkg::ST_START_BIT]   = st_reg.start_fit;
                st_next.prdata[dsod_pkg::ST_SPIN_BIT]    = st_reg.spindle;
                st_next.prdata[dsod_pkg::ST_LATCH_BIT]   = st_reg.latched;
            end else if (paddr != dsod_pkg::SPIN_CMD_OFFSET) begin
                st_next.pslverr = 1'b1;
            end
        end

        // spindle control, straps sampled once after release
        case (st_reg.spin)
            dsod_pkg::SPIN_WAIT: begin
                st_next.wait_cnt = st_reg.wait_cnt + 3'h1;
                if (latch_now) begin
                    st_next.latched   = 1'b1;                           // RQ9
                    st_next.bus_id    = id_live;                        // RQ1
                    st_next.start_fit = sif.q[dsod_pkg::SV_START_BIT];  // RQ9
                    if (sif.q[dsod_pkg::SV_START_BIT]) begin
                        st_next.spin    = dsod_pkg::SPIN_RUNNING;       // RQ6
                        st_next.spindle = 1'b1;
                    end else begin
                        st_next.spin    = dsod_pkg::SPIN_STOPPED;       // RQ6
                        st_next.spindle = 1'b0;
                    end
                end
            end
            dsod_pkg::SPIN_STOPPED: begin
                if (cmd_start && !cmd_stop) begin
                    st_next.spin    = dsod_pkg::SPIN_RUNNING;           // RQ7
                    st_next.spindle = 1'b1;
                end
            end
            dsod_pkg::SPIN_RUNNING: begin
                // stop wins when both bits are written together
                if (cmd_stop) begin
                    st_next.spin    = dsod_pkg::SPIN_STOPPED;           // RQ7
                    st_next.spindle = 1'b0;
                end
            end
            default: begin
                st_next.spin    = dsod_pkg::SPIN_STOPPED;
                st_next.spindle = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{wait_cnt: 3'h0, spin: dsod_pkg::SPIN_WAIT,
                        bus_id: dsod_pkg::BUS_ID_RST, prdata: 32'h0000_0000,
                        default: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata         = st_reg.prdata;
    assign pready         = st_reg.pready;
    assign pslverr        = st_reg.pslverr;
    assign wr_grant       = st_reg.wr_grant;
    assign wr_refused     = st_reg.wr_refused;
    assign bus_id         = st_reg.bus_id;
    assign self_test_mode = st_reg.self_test;
    assign spindle_run    = st_reg.spindle;
    assign arb_win        = st_reg.arb_win;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_cmd_start;
        cmd_start && !cmd_stop && st_reg.latched;
    endsequence
    sequence s_cmd_stop;
        cmd_stop && st_reg.latched;
    endsequence

    AST_ID_LATCH: assert property (latch_now |=> bus_id == $past(id_live)) // RQ1
        else $error("bus id differs from straps at latch");
    AST_ID_HOLD: assert property (st_reg.latched |=> $stable(bus_id) && st_reg.latched) // RQ9
        else $error("latched bus id changed");
    // own bit present and nothing above it; id seven must not wrap the shift
    AST_ARB_HIGHER: assert property (arb_win |-> // RQ2
        ($past(arb_live) >> $past(bus_id)) == 8'h01)
        else $error("arbitration won against a higher id");
    AST_WP_REFUSE: assert property (wr_req && !wp_fit |=> wr_refused && !wr_grant) // RQ4
        else $error("write not refused while protected");
    AST_WP_GRANT: assert property (wr_req && wp_fit |=> wr_grant && !wr_refused) // RQ5
        else $error("write not granted while strap fitted");
    AST_DIAG_LIVE: assert property ($changed(sif.q[dsod_pkg::SV_DIAG_BIT]) |=> // RQ5
        self_test_mode == $past(sif.q[dsod_pkg::SV_DIAG_BIT]))
        else $error("self test mode did not follow strap");
    AST_AUTO_SPIN: assert property (latch_now && sif.q[dsod_pkg::SV_START_BIT] |=> spindle_run) // RQ6
        else $error("spindle did not start at power-on");
    AST_WAIT_SPIN: assert property (latch_now && !sif.q[dsod_pkg::SV_START_BIT] |=> !spindle_run) // RQ6
        else $error("spindle started without command");
    AST_CMD_START: assert property (s_cmd_start |=> spindle_run) // RQ7
        else $error("start command ignored");
    AST_CMD_STOP: assert property (s_cmd_stop |=> !spindle_run [*2]) // RQ7
        else $error("stop command ignored");
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready) // apb one wait state
        else $error("apb answer late");

endmodule

// >>> tb/dsod_host_model.sv
`timescale 1ns/1ps
module dsod_host_model (
    input  wire logic       pclk,
    input  wire logic [2:0] dev_id,
    output logic            arb_phase,
    output logic [7:0]      arb_bus
);
    // ****************************************
    // initiator contending for the bus
    // ****************************************
    // terminated lines rest deasserted, so a released bus reads zero
    initial begin
        arb_phase = 1'b0;
        arb_bus   = 8'h00;
    end

    // wired-or of both parties' id bits; caller keeps the ids distinct
    task automatic contend(input logic [2:0] host_id);
        @(posedge pclk);
        arb_phase <= 1'b1;
        arb_bus   <= (8'h01 << host_id) | (8'h01 << dev_id);
    endtask

    // drop off the bus right after an edge
    task automatic release_bus();
        @(posedge pclk);
        arb_phase <= 1'b0;
        arb_bus   <= 8'h00;
    endtask
endmodule

// >>> tb/drive_strap_option_decoder_test.sv
`timescale 1ns/1ps
module drive_strap_option_decoder_test;
    // ****************************************
    // signals and case table
    // ****************************************
    typedef struct packed {
        logic [2:0] id;
        logic       st;
        logic [2:0] pnl_n;
        logic [2:0] exp;
    } dsod_row_s;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr, arb_bus;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  id_strap, bus_id;
    logic        wp, diag, start, p2_n, p1, p0_n, wr_req, arb_phase;
    logic        wr_grant, wr_refused, self_test_mode, spindle_run, arb_win;
    int          n_errors, comparisons, cycles;
    // panel bits are {bit2_n, bit1, bit0_n}, all active low
    dsod_row_s   rows[10] = '{'{3'h7, 1'b1, 3'h7, 3'h7}, '{3'h0, 1'b0, 3'h7, 3'h0},
                              '{3'h1, 1'b1, 3'h7, 3'h1}, '{3'h2, 1'b0, 3'h7, 3'h2},
                              '{3'h3, 1'b1, 3'h7, 3'h3}, '{3'h4, 1'b0, 3'h7, 3'h4},
                              '{3'h5, 1'b1, 3'h7, 3'h5}, '{3'h6, 1'b0, 3'h7, 3'h6},
                              '{3'h0, 1'b1, 3'h6, 3'h1}, '{3'h1, 1'b0, 3'h1, 3'h7}};

    dsod_strap_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .identifier_strap_header(id_strap), .wp_strap(wp),
        .self_test_strap(diag), .start_mode_strap(start), .panel_id_bit2_n(p2_n),
        .panel_id_bit1(p1), .panel_id_bit0_n(p0_n), .arb_bus(arb_bus), .arb_phase(arb_phase),
        .wr_req(wr_req), .wr_grant(wr_grant), .wr_refused(wr_refused), .bus_id(bus_id),
        .self_test_mode(self_test_mode), .spindle_run(spindle_run), .arb_win(arb_win));
    dsod_host_model host_u (.pclk(pclk), .dev_id(bus_id), .arb_phase(arb_phase),
        .arb_bus(arb_bus));

    // ****************************************
    // clock, watchdog and helpers
    // ****************************************
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // a hang costs a mismatch; real run is about 400 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // straps must already be set; waits well past the latch point
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
    endtask

    // one apb transfer, returns one edge after the edge that takes it
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // answer only moves on a rising edge, so the falling-edge level is
        // what the next rising edge samples; no race with the launch edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        @(posedge pclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in this step
        @(posedge pclk);
        chk("pready wait", 32'h2, 32'(n));
    endtask

    // one-cycle write request, answer looked at in its only cycle
    task automatic wr_pulse(input logic ok);
        wr_req <= 1'b1;
        @(posedge pclk);
        wr_req <= 1'b0;
        #1;
        chk("wr_grant", 32'(ok), 32'(wr_grant));
        chk("wr_refused", 32'(!ok), 32'(wr_refused));
        @(posedge pclk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, wr_req, diag} = 6'h00;
        {paddr, pwdata, wp, start, id_strap, p2_n, p1, p0_n} = '1;
        foreach (rows[i]) begin
            id_strap <= rows[i].id;
            start    <= rows[i].st;
            {p2_n, p1, p0_n} <= rows[i].pnl_n;
            do_reset();
            chk("bus_id", 32'(rows[i].exp), 32'(bus_id));
            chk("spindle", 32'(rows[i].st), 32'(spindle_run));
            apb(1'b0, dsod_pkg::STATUS_OFFSET, 32'h0);
            chk("status", {24'h0, 1'b1, {2{rows[i].st}}, 1'b0, 1'b1, rows[i].exp}, rd);
        end
        $display("test table done");
        // late strap changes stay out of the latched values
        id_strap <= 3'h2;
        start    <= 1'b1;
        {p2_n, p1, p0_n} <= 3'h7;
        repeat (8) @(posedge pclk);
        chk("held bus_id", 32'h7, 32'(bus_id));
        chk("held spindle", 32'h0, 32'(spindle_run));
        $display("test latch hold done");
        wr_pulse(1'b1);
        wp <= 1'b0;
        repeat (6) @(posedge pclk);
        wr_pulse(1'b0);
        wp   <= 1'b1;
        diag <= 1'b1;
        repeat (6) @(posedge pclk);
        wr_pulse(1'b1);
        chk("self test on", 32'h1, 32'(self_test_mode));
        diag <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("self test off", 32'h0, 32'(self_test_mode));
        $display("test live straps done");
        // spindle commands in both start modes, stop wins a tie
        id_strap <= 3'h3;
        start    <= 1'b0;
        do_reset();
        chk("spin wait", 32'h0, 32'(spindle_run));
        for (int c = 1; c <= 5; c++) begin
            if (c == 4) begin
                start <= 1'b1;
                do_reset();
                chk("spin poweron", 32'h1, 32'(spindle_run));
            end
            // c3 both bits while stopped, c4 both bits while running: stop wins
            apb(1'b1, dsod_pkg::SPIN_CMD_OFFSET, 32'((c == 1 || c == 5) ? 1 : (c == 2 ? 2 : 3)));
            @(posedge pclk);
            chk("spindle cmd", 32'(c == 1 || c == 5), 32'(spindle_run));
        end
        $display("test spindle done");
        // refused accesses, then a command register read that is not refused
        apb(1'b1, dsod_pkg::STATUS_OFFSET, 32'h0);
        chk("status write err", 32'h1, 32'(err));
        apb(1'b0, 8'h08, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b0, dsod_pkg::SPIN_CMD_OFFSET, 32'h0);
        chk("cmd read", 32'h0, rd);
        chk("cmd read err", 32'h0, 32'(err));
        $display("test apb refusals done");
        // contend against every other id, our latched id is 3
        for (int h = 0; h < 8; h++) begin
            if (h != 3) begin
                host_u.contend(3'(h));
                repeat (8) @(posedge pclk);
                chk("arb_win", 32'(h < 3), 32'(arb_win));
                host_u.release_bus();
                repeat (8) @(posedge pclk);
                chk("arb idle", 32'h0, 32'(arb_win));
            end
        end
        $display("test arbitration done");
        wrap_up();
    end
endmodule
